// file: pbc_pkg.sv
// package for the loop bandwidth and divider control block
// assumes a 32-bit ahb-lite bus, one word per register
package pbc_pkg;
    localparam logic [7:0]  PBC_OFS_CTRL     = 8'h00;
    localparam logic [7:0]  PBC_OFS_BW       = 8'h04;
    localparam logic [7:0]  PBC_OFS_MUL_HI   = 8'h08;
    localparam logic [7:0]  PBC_OFS_MUL_LO   = 8'h0c;
    localparam logic [7:0]  PBC_OFS_RANGE    = 8'h10;
    localparam logic [7:0]  PBC_OFS_REFDIV   = 8'h14;
    localparam logic [7:0]  PBC_OFS_SYS      = 8'h18;
    // control register bit positions
    localparam int          PBC_CTL_IE       = 7;
    localparam int          PBC_CTL_FLAG     = 6;
    localparam int          PBC_CTL_ON       = 5;
    localparam int          PBC_CTL_BCS      = 4;
    // bandwidth register bit positions
    localparam int          PBC_BW_AUTO      = 7;
    localparam int          PBC_BW_LOCK      = 6;
    localparam int          PBC_BW_TRACK     = 5;
    // system register bit positions
    localparam int          PBC_SYS_BREAK_CLEAR_ENABLE     = 0;
    localparam int          PBC_SYS_BRK      = 1;
    localparam int          PBC_SYS_WAIT     = 2;
    localparam int          PBC_SYS_STOP     = 3;
    // reset values
    localparam logic [11:0] PBC_MUL_RST      = 12'h040;
    localparam logic [7:0]  PBC_RANGE_RST    = 8'h40;
    localparam logic [3:0]  PBC_REFDIV_RST   = 4'h1;
    localparam logic [1:0]  PBC_PRE_RST      = 2'h0;
    localparam logic [1:0]  PBC_VPR_RST      = 2'h0;
    typedef enum logic [1:0] {PBC_PH_IDLE, PBC_PH_DATA} pbc_phase_t;
endpackage

// file: pbc_lock_if.sv
// link between the control block and its lock change detector
// assumes one clock for both ends
`timescale 1ns/1ps
interface pbc_lock_if;
    logic lock_sync;
    logic lock_edge;
    modport det (output lock_sync, output lock_edge);
    modport ctl (input lock_sync, input lock_edge);
endinterface

// file: pbc_lock_det.sv
// lock detector synchroniser and edge finder
// assumes lock_raw comes from the analog loop, asynchronous to clk_sys
`timescale 1ns/1ps
module pbc_lock_det
    import pbc_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // raw lock level
    input  wire logic lock_raw,
    // to control
    pbc_lock_if.det   lk
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // two flops before use; s3 only feeds the edge compare
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= lock_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    assign lk.lock_sync = s2_reg;
    assign lk.lock_edge = s2_reg ^ s3_reg;

    edge_both_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ($changed(s2_reg)) |-> lk.lock_edge)
        else $error("lock change not reported");
endmodule

// file: pbc_ctrl.sv
// loop bandwidth and divider control with ahb-lite register slave
// assumes a single ahb-lite master, one clock, async active-high reset
// Overview of operation
// - bandwidth mode bit: 1 automatic, 0 manual; reset gives manual
// - lock bit reads loop lock in automatic mode, 0 in manual
// - mode bit tracking=1; status in automatic, control in manual
// - manual mode value kept through automatic mode; reset selects acquisition
// - multiplier zero acts as one; reset value 64
// - multiplier writes ignored while loop enabled
// - range writes ignored while loop enabled; reset 0x40
// - zero range disables loop and clears base clock select
// - base clock select cannot set while range is zero
// - reference divider locked while enabled, zero acts as one, reset 1
// - every lock change in automatic mode sets the flag; irq only when enabled
// - manual mode: no irq, flag reads zero
// - base clock select allowed while unlocked
// - wait mode leaves the generator unchanged
// - stop mode powers down loop analog, no loop clock
// - in break, control access clears flag only if break clear enabled
// - a read of control register clears the flag, except in break with break clear disabled
// - irq enable ignores writes, reads zero in manual mode
// - enable cannot clear with select set; select cannot set with enable off
//
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module pbc_ctrl
    import pbc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // analog loop
    input  wire logic        lock_raw,
    input  wire logic        brk_active,
    input  wire logic        stop_mode,
    input  wire logic        wait_mode,
    output logic             analog_enable,
    output logic             loop_bw_auto,
    output logic             loop_track,
    output logic      [11:0] feedback_multiplier,
    output logic      [7:0]  range_multiplier,
    output logic      [3:0]  reference_divide,
    output logic      [1:0]  prescale_sel,
    output logic      [1:0]  vco_power_sel,
    output logic             base_clock_select,
    output logic             lock_irq
);
    pbc_lock_if lk();

    pbc_lock_det u_det (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .lock_raw(lock_raw),
        .lk      (lk)
    );

    // registers
    logic        auto_reg;
    logic        track_man_reg;
    logic        ie_reg;
    logic        flag_reg;
    logic        on_reg;
    logic        bcs_reg;
    logic        break_clear_enable_reg;
    logic [1:0]  pre_reg;
    logic [1:0]  vpr_reg;
    logic [11:0] mul_reg;
    logic [7:0]  range_reg;
    logic [3:0]  rdiv_reg;
    logic [31:0] hrdata_reg;

    // bus capture
    pbc_phase_t  ph_reg;
    logic [7:0]  adr_reg;
    logic        wr_reg;

    logic        ap_take;
    logic        wr_go;
    logic        rd_take;
    logic        lock_vis;
    logic        flag_vis;
    logic        ctl_clr;
    logic [7:0]  ctl_rd;
    logic [7:0]  bw_rd;
    logic [7:0]  wd;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    assign ap_take   = hsel && hready && htrans[1];
    assign rd_take   = ap_take && !hwrite;
    assign wr_go     = (ph_reg == PBC_PH_DATA) && wr_reg;
    assign wd        = hwdata[7:0];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ph_reg  <= PBC_PH_IDLE;
            adr_reg <= 8'h00;
            wr_reg  <= 1'b0;
        end else begin
            ph_reg  <= ap_take ? PBC_PH_DATA : PBC_PH_IDLE;
            adr_reg <= ap_take ? haddr : adr_reg;
            wr_reg  <= ap_take && hwrite;
        end
    end

    assign lock_vis = auto_reg && lk.lock_sync;
    assign flag_vis = auto_reg && flag_reg;
    // flag clears on read of control unless frozen by break with break clear disabled
    assign ctl_clr  = rd_take && hit(haddr, PBC_OFS_CTRL) && (!brk_active || break_clear_enable_reg);

    assign ctl_rd = {ie_reg && auto_reg, flag_vis, on_reg, bcs_reg, pre_reg, vpr_reg};
    assign bw_rd  = {auto_reg, lock_vis, loop_track, 5'h00};

    // read data captured in address phase so the read is a single-cycle answer
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (rd_take) begin
            if (hit(haddr, PBC_OFS_CTRL))
                hrdata_reg <= {24'h000000, ctl_rd};
            else if (hit(haddr, PBC_OFS_BW))
                hrdata_reg <= {24'h000000, bw_rd};
            else if (hit(haddr, PBC_OFS_MUL_HI))
                hrdata_reg <= {28'h0000000, mul_reg[11:8]};
            else if (hit(haddr, PBC_OFS_MUL_LO))
                hrdata_reg <= {24'h000000, mul_reg[7:0]};
            else if (hit(haddr, PBC_OFS_RANGE))
                hrdata_reg <= {24'h000000, range_reg};
            else if (hit(haddr, PBC_OFS_REFDIV))
                hrdata_reg <= {28'h0000000, rdiv_reg};
            else if (hit(haddr, PBC_OFS_SYS))
                hrdata_reg <= {28'h0000000, stop_mode, wait_mode, brk_active, break_clear_enable_reg};
            else
                hrdata_reg <= 32'h0000_0000;
        end
    end
    assign hrdata = hrdata_reg;

    // bandwidth register; lock bit writes dropped, test function unsupported
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            auto_reg      <= 1'b0;
            track_man_reg <= 1'b0;
        end else if (wr_go && hit(adr_reg, PBC_OFS_BW)) begin
            auto_reg <= wd[PBC_BW_AUTO];
            // manual value only written while manual, so it survives auto
            if (!auto_reg)
                track_man_reg <= wd[PBC_BW_TRACK];
        end
    end

    // automatic mode reports tracking once locked
    assign loop_track = auto_reg ? lk.lock_sync : track_man_reg;

    // control register
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ie_reg  <= 1'b0;
            on_reg  <= 1'b1;
            bcs_reg <= 1'b0;
            pre_reg <= PBC_PRE_RST;
            vpr_reg <= PBC_VPR_RST;
        end else begin
            if (wr_go && hit(adr_reg, PBC_OFS_CTRL)) begin
                if (auto_reg)
                    ie_reg <= wd[PBC_CTL_IE];
                on_reg  <= wd[PBC_CTL_ON] || bcs_reg;
                // no lock check here
                bcs_reg <= wd[PBC_CTL_BCS] && on_reg && (range_reg != 8'h00);
                if (!on_reg) begin
                    pre_reg <= wd[3:2];
                    vpr_reg <= wd[1:0];
                end
            end
            if (range_reg == 8'h00) begin
                on_reg  <= 1'b0;
                bcs_reg <= 1'b0;
            end
        end
    end

    // divider registers, frozen while the loop is on
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mul_reg   <= PBC_MUL_RST;
            range_reg <= PBC_RANGE_RST;
            rdiv_reg  <= PBC_REFDIV_RST;
        end else if (wr_go && !on_reg) begin
            if (hit(adr_reg, PBC_OFS_MUL_HI))
                mul_reg[11:8] <= wd[3:0];
            if (hit(adr_reg, PBC_OFS_MUL_LO))
                mul_reg[7:0] <= wd;
            if (hit(adr_reg, PBC_OFS_RANGE))
                range_reg <= wd;
            if (hit(adr_reg, PBC_OFS_REFDIV))
                rdiv_reg <= wd[3:0];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            break_clear_enable_reg <= 1'b0;
        else if (wr_go && hit(adr_reg, PBC_OFS_SYS))
            break_clear_enable_reg <= wd[PBC_SYS_BREAK_CLEAR_ENABLE];
    end

    // lock change flag; a new edge wins over a clearing read
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            flag_reg <= 1'b0;
        else if (auto_reg && lk.lock_edge)
            flag_reg <= 1'b1;
        else if (!auto_reg)
            flag_reg <= 1'b0;
        else if (ctl_clr)
            flag_reg <= 1'b0;
    end

    // outputs to the analog loop; zero multiplier and zero divider act as one
    assign feedback_multiplier = (mul_reg == 12'h000) ? 12'h001 : mul_reg;
    assign reference_divide    = (rdiv_reg == 4'h0) ? 4'h1 : rdiv_reg;
    assign range_multiplier    = range_reg;
    assign prescale_sel        = pre_reg;
    assign vco_power_sel       = vpr_reg;
    assign base_clock_select   = bcs_reg;
    assign loop_bw_auto        = auto_reg;
    // wait mode is deliberately not used here
    assign analog_enable       = on_reg && !stop_mode;
    assign lock_irq            = flag_vis && ie_reg;

    // checks; multi-step conditions are named sequences
    sequence s_on_write_attempt;
        wr_go && on_reg && hit(adr_reg, PBC_OFS_MUL_LO);
    endsequence

    sequence s_ctl_write_manual;
        wr_go && hit(adr_reg, PBC_OFS_CTRL) && !auto_reg;
    endsequence

    sequence s_ctl_read_clear;
        ctl_clr && auto_reg && !lk.lock_edge;
    endsequence

    sequence s_brk_protect;
        brk_active && !break_clear_enable_reg && flag_reg && auto_reg;
    endsequence

    // two auto cycles in a row: the stored manual value must not move
    sequence s_auto_span;
        auto_reg ##1 auto_reg;
    endsequence

    // divider settings frozen while the loop runs; zero multiplier shown as one
    mul_frozen_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_on_write_attempt |=> $stable(mul_reg[7:0]))
        else $error("multiplier changed while loop on");
    mul_hi_frozen_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (wr_go && on_reg) |=> $stable(mul_reg[11:8]))
        else $error("multiplier high changed while loop on");
    range_frozen_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (wr_go && on_reg) |=> $stable(range_reg))
        else $error("range changed while loop on");
    rdiv_frozen_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (wr_go && on_reg) |=> $stable(rdiv_reg))
        else $error("divider changed while loop on");
    mul_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (mul_reg == 12'h000) |-> (feedback_multiplier == 12'h001))
        else $error("zero multiplier not shown as one");

    // enable and select interlocks
    zero_range_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (range_reg == 8'h00) |=> (!bcs_reg && !on_reg))
        else $error("zero range left loop selected");
    sel_range_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(bcs_reg) |-> ($past(range_reg) != 8'h00))
        else $error("select set with zero range");
    bcs_guard_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ($rose(bcs_reg)) |-> $past(on_reg))
        else $error("select set with loop off");
    on_guard_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ($fell(on_reg) && $past(range_reg) != 8'h00) |-> !$past(bcs_reg))
        else $error("loop cleared while selected");

    // lock change flag and interrupt
    flag_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (auto_reg && lk.lock_edge) |=> flag_reg)
        else $error("lock change missed");
    flag_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_ctl_read_clear |=> !flag_reg)
        else $error("control read left flag set");
    manual_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !auto_reg |=> !flag_reg)
        else $error("flag held in manual mode");
    irq_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        lock_irq |-> (auto_reg && ie_reg && flag_reg))
        else $error("irq without enabled flag");
    manual_quiet_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !auto_reg |-> (!lock_irq && !ctl_rd[PBC_CTL_FLAG] && !bw_rd[PBC_BW_LOCK]))
        else $error("manual mode shows lock status");
    brk_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_brk_protect |=> flag_reg)
        else $error("flag cleared in break");
    break_clear_enable_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (wr_go && hit(adr_reg, PBC_OFS_SYS)) |=> (break_clear_enable_reg == $past(wd[PBC_SYS_BREAK_CLEAR_ENABLE])))
        else $error("break clear enable not written");

    // register readback and mode bits
    ie_manual_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_ctl_write_manual |=> $stable(ie_reg))
        else $error("irq enable written in manual mode");
    ie_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (rd_take && hit(haddr, PBC_OFS_CTRL) && !auto_reg) |=> !hrdata[PBC_CTL_IE])
        else $error("irq enable read as one in manual mode");
    lock_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (rd_take && hit(haddr, PBC_OFS_BW) && auto_reg) |=> (hrdata[PBC_BW_LOCK] == $past(lk.lock_sync)))
        else $error("lock bit read wrong in auto mode");
    track_keep_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_auto_span |-> $stable(track_man_reg))
        else $error("manual mode bit lost in auto");

    // low power modes
    wait_same_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (wait_mode && !stop_mode && on_reg) |-> analog_enable)
        else $error("wait mode changed the loop");
    stop_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        stop_mode |-> !analog_enable)
        else $error("loop on in stop");
endmodule

// file: pbc_tb.sv
// self-checking bench for the loop bandwidth and divider control block
// assumes pbc_pkg, pbc_lock_if, pbc_lock_det and pbc_ctrl are compiled first
`timescale 1ns/1ps
module testbench
    import pbc_pkg::*;
;
    logic        clk_sys;
    logic        sys_rst;
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        lock_raw;
    logic        brk_active;
    logic        stop_mode;
    logic        wait_mode;
    logic        analog_enable;
    logic        loop_bw_auto;
    logic        loop_track;
    logic [11:0] feedback_multiplier;
    logic [7:0]  range_multiplier;
    logic [3:0]  reference_divide;
    logic [1:0]  prescale_sel;
    logic [1:0]  vco_power_sel;
    logic        base_clock_select;
    logic        lock_irq;
    int          fails;
    int          compares;
    logic [31:0] seed;
    logic [31:0] rv;

    pbc_ctrl u_pbc_ctrl (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .lock_raw(lock_raw), .brk_active(brk_active),
        .stop_mode(stop_mode), .wait_mode(wait_mode), .analog_enable(analog_enable),
        .loop_bw_auto(loop_bw_auto), .loop_track(loop_track), .feedback_multiplier(feedback_multiplier),
        .range_multiplier(range_multiplier), .reference_divide(reference_divide),
        .prescale_sel(prescale_sel), .vco_power_sel(vco_power_sel),
        .base_clock_select(base_clock_select), .lock_irq(lock_irq)
    );

    always #10 clk_sys = ~clk_sys;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return s[0] ? ({1'b0, s[31:1]} ^ 32'h80200003) : {1'b0, s[31:1]};
    endfunction

    // zero programs the same divide as one
    function automatic logic [11:0] zero_as_one(input logic [11:0] v);
        return (v == 12'h000) ? 12'h001 : v;
    endfunction

    task automatic print_verdict();
        if (fails == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one single ahb-lite transfer; no answer time assumed, a hang is left to the watchdog
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= 3'b010;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? wd : 32'h0;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hreadyout", 32'(hreadyout), 32'h1);
        chk("hresp", 32'(hresp), 32'h0);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        chk($sformatf("read %h", a), d, exp);
    endtask

    // change the raw lock level, then let synchroniser and edge finder settle
    task automatic lk(input logic v);
        @(posedge clk_sys);
        lock_raw <= v;
        repeat (6) @(posedge clk_sys);
        #1;
    endtask

    initial begin
        #100000;
        fails++;
        print_verdict();
    end

    initial begin
        clk_sys = 1'b0; sys_rst = 1'b1; hsel = 1'b0; haddr = 8'h00; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'b010; hwdata = 32'h0; lock_raw = 1'b0; brk_active = 1'b0; stop_mode = 1'b0;
        wait_mode = 1'b0; fails = 0; compares = 0; seed = 32'hce1f;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        chk("mul out", 32'(feedback_multiplier), 32'h040);
        chk("range out", 32'(range_multiplier), 32'h40);
        chk("div out", 32'(reference_divide), 32'h1);
        chk("auto", 32'(loop_bw_auto), 32'h0);
        chk("analog", 32'(analog_enable), 32'h1);
        rc(PBC_OFS_CTRL, 32'h20);
        rc(PBC_OFS_BW, 32'h00);
        rc(PBC_OFS_MUL_HI, 32'h00);
        rc(PBC_OFS_MUL_LO, 32'h40);
        rc(PBC_OFS_RANGE, 32'h40);
        rc(PBC_OFS_REFDIV, 32'h01);
        wr(8'h1c, 32'hff);
        rc(8'h1c, 32'h00);
        // loop running: divider settings locked
        wr(PBC_OFS_MUL_LO, 32'h55);
        wr(PBC_OFS_RANGE, 32'h11);
        wr(PBC_OFS_REFDIV, 32'h05);
        wr(PBC_OFS_CTRL, 32'h2f);
        rc(PBC_OFS_MUL_LO, 32'h40);
        rc(PBC_OFS_RANGE, 32'h40);
        rc(PBC_OFS_REFDIV, 32'h01);
        rc(PBC_OFS_CTRL, 32'h20);
        // select while unlocked, then the enable/select interlock
        wr(PBC_OFS_CTRL, 32'h30);
        chk("bcs out", 32'(base_clock_select), 32'h1);
        wr(PBC_OFS_CTRL, 32'h00);
        rc(PBC_OFS_CTRL, 32'h20);
        wr(PBC_OFS_CTRL, 32'h00);
        chk("analog", 32'(analog_enable), 32'h0);
        wr(PBC_OFS_CTRL, 32'h10);
        rc(PBC_OFS_CTRL, 32'h00);
        wr(PBC_OFS_MUL_HI, 32'h00);
        wr(PBC_OFS_MUL_LO, 32'h00);
        wr(PBC_OFS_REFDIV, 32'h00);
        chk("mul out", 32'(feedback_multiplier), 32'h001);
        chk("div out", 32'(reference_divide), 32'h1);
        wr(PBC_OFS_REFDIV, 32'h01);
        rc(PBC_OFS_REFDIV, 32'h01);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr_next(seed);
            rv = seed;
            wr(PBC_OFS_MUL_HI, {28'h0, rv[11:8]});
            wr(PBC_OFS_MUL_LO, {24'h0, rv[7:0]});
            wr(PBC_OFS_RANGE, {24'h0, rv[23:16] | 8'h01});
            chk("mul out", 32'(feedback_multiplier), 32'(zero_as_one(rv[11:0])));
            rc(PBC_OFS_RANGE, {24'h0, rv[23:16] | 8'h01});
        end
        // zero range keeps the loop and the select from being set
        wr(PBC_OFS_RANGE, 32'h00);
        wr(PBC_OFS_CTRL, 32'h30);
        rc(PBC_OFS_CTRL, 32'h00);
        chk("bcs out", 32'(base_clock_select), 32'h0);
        wr(PBC_OFS_RANGE, 32'h40);
        wr(PBC_OFS_CTRL, 32'h0e);
        chk("pre/vpr", {28'h0, prescale_sel, vco_power_sel}, 32'he);
        wr(PBC_OFS_BW, 32'h00);
        wr(PBC_OFS_CTRL, 32'h20);
        // manual mode: no flag, no irq, lock reads zero
        wr(PBC_OFS_CTRL, 32'ha0);
        rc(PBC_OFS_CTRL, 32'h20);
        lk(1'b1);
        chk("irq", 32'(lock_irq), 32'h0);
        rc(PBC_OFS_CTRL, 32'h20);
        rc(PBC_OFS_BW, 32'h00);
        lk(1'b0);
        // manual track value survives automatic mode; lock bit always written 0
        wr(PBC_OFS_BW, 32'h20);
        chk("track", 32'(loop_track), 32'h1);
        wr(PBC_OFS_BW, 32'ha0);
        chk("auto", 32'(loop_bw_auto), 32'h1);
        chk("track", 32'(loop_track), 32'h0);
        wr(PBC_OFS_BW, 32'h00);
        rc(PBC_OFS_BW, 32'h20);
        // automatic mode lock change events
        wr(PBC_OFS_BW, 32'h80);
        wr(PBC_OFS_CTRL, 32'ha0);
        lk(1'b1);
        chk("irq", 32'(lock_irq), 32'h1);
        rc(PBC_OFS_BW, 32'he0);
        rc(PBC_OFS_CTRL, 32'he0);
        chk("irq", 32'(lock_irq), 32'h0);
        rc(PBC_OFS_CTRL, 32'ha0);
        // break protects the flag unless clearing is enabled
        @(posedge clk_sys);
        brk_active <= 1'b1;
        lk(1'b0);
        rc(PBC_OFS_CTRL, 32'he0);
        rc(PBC_OFS_CTRL, 32'he0);
        wr(PBC_OFS_SYS, 32'h01);
        rc(PBC_OFS_SYS, 32'h03);
        rc(PBC_OFS_CTRL, 32'he0);
        @(posedge clk_sys);
        brk_active <= 1'b0;
        rc(PBC_OFS_CTRL, 32'ha0);
        wr(PBC_OFS_SYS, 32'h00);
        // flag sets with irq disabled
        wr(PBC_OFS_CTRL, 32'h20);
        lk(1'b1);
        chk("irq", 32'(lock_irq), 32'h0);
        rc(PBC_OFS_CTRL, 32'h60);
        // locked: select the loop clock, then wait and stop
        rc(PBC_OFS_BW, 32'he0);
        wr(PBC_OFS_CTRL, 32'h30);
        chk("bcs out", 32'(base_clock_select), 32'h1);
        @(posedge clk_sys);
        wait_mode <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk("analog", 32'(analog_enable), 32'h1);
        chk("bcs out", 32'(base_clock_select), 32'h1);
        wr(PBC_OFS_CTRL, 32'h20);
        @(posedge clk_sys);
        wait_mode <= 1'b0;
        stop_mode <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk("analog", 32'(analog_enable), 32'h0);
        @(posedge clk_sys);
        stop_mode <= 1'b0;
        wr(PBC_OFS_CTRL, 32'h20);
        rc(PBC_OFS_BW, 32'he0);
        wr(PBC_OFS_CTRL, 32'h30);
        chk("bcs out", 32'(base_clock_select), 32'h1);
        chk("analog", 32'(analog_enable), 32'h1);
        print_verdict();
    end
endmodule
